// ---- inc/qspi_irq_pkg.sv ----
// constants for the serial interface interrupt enable and flag logic
package qspi_irq_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_ENABLE_CLEAR = 8'h14;
    localparam logic [7:0] OFS_ENABLE_SET = 8'h18;
    localparam logic [7:0] OFS_FLAGS = 8'h1C;
    localparam logic [7:0] OFS_RECEIVE_DATA = 8'h0C;
    localparam logic [7:0] OFS_TRANSMIT_DATA = 8'h10;
    localparam logic [7:0] OFS_CONTROL = 8'h24;
    // field positions
    localparam int BIT_RECEIVE_FULL = 0;
    localparam int BIT_TRANSMIT_EMPTY = 1;
    localparam int BIT_TRANSMIT_COMPLETE = 2;
    localparam int BIT_OVERRUN = 3;
    localparam int BIT_SELECT_RISE = 8;
    localparam int BIT_INSTRUCTION_END = 10;
    localparam int BIT_CTRL_ENABLE = 1;
    // implemented bit mask and reset values
    localparam logic [31:0] IRQ_MASK = 32'h0000050F;
    localparam logic [31:0] IRQ_RESET = 32'h00000000;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'h0;
    // default transfer delay in peripheral clocks
    localparam int DELAY_CYCLES_DEFAULT = 0;
endpackage

// ---- rtl/qspi_irq_enable_flag_logic.sv ----
// interrupt enable and flag logic of the quad serial interface controller
//
// Functional notes
// - writing one to an enable-set bit turns that enable on; zero does nothing
// - enable-set reads return the enables; all enables reset to zero
// - instruction-end flag bit 10 sets on end of instruction
// - select-rise flag bit 8 sets on rising chip select
// - overrun flag bit 3 sets when receive register reloaded while unread
// - writing one clears instruction-end, select-rise, overrun flags; zero ignored
// - transmit-complete flag drops as soon as the transmit register is written
// - transmit-complete sets when transmit register and shifter are both empty
// - with a transfer delay, transmit-complete sets only after that delay
// - transmit-empty stays low from transmit write until serializer takes word
// - transmit-empty sets when the last written word reaches the serializer
// - transmit-empty reads zero while disabled and after reset
// - transmit-empty sets at once when the controller enable becomes set
// - writing one to an enable-clear bit turns that enable off
// - receive-full sets on receive load, is zero after the register is read
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
module qspi_irq_enable_flag_logic
    import qspi_irq_pkg::*;
#(
    parameter int DELAY_W = 8
) (
    // clock, reset, clock enable
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // controller events
    input wire logic instr_end_evt,
    input wire logic cs_rise_evt,
    input wire logic rx_load,
    input wire logic tx_take,
    input wire logic shifter_busy,
    input wire logic [DELAY_W-1:0] xfer_delay,
    // controller side
    output logic tx_write,
    output logic rx_read,
    output logic ctrl_enable,
    output logic irq
);

    // ----------------------------------------------------------------
    // bus address phase capture
    // ----------------------------------------------------------------
    logic wr_pend_r;
    logic rd_pend_r;
    logic [7:0] addr_r;
    logic [31:0] enables_r;
    logic [31:0] flags_r;
    logic ctrl_en_r;
    logic tx_pending_r;
    logic [DELAY_W-1:0] delay_cnt_r;
    logic delay_run_r;
    logic ctrl_en_d_r;
    logic [31:0] rdata_nxt;
    logic [31:0] wmask;
    logic fl_write;
    logic tx_wr;
    logic rx_rd;
    logic tx_empty_path;
    logic addr_ok;

    assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else if (clk_en) begin
            wr_pend_r <= addr_ok && hwrite;
            rd_pend_r <= addr_ok && !hwrite;
            if (addr_ok) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    assign wmask = hwdata & IRQ_MASK;
    assign fl_write = wr_pend_r && addr_r == OFS_FLAGS;
    assign tx_wr = wr_pend_r && addr_r == OFS_TRANSMIT_DATA;
    // a read of the receive register is taken at its address phase
    assign rx_rd = addr_ok && !hwrite && haddr[7:0] == OFS_RECEIVE_DATA;

    // ----------------------------------------------------------------
    // enables
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            enables_r <= IRQ_RESET;
        end else if (clk_en && wr_pend_r) begin
            if (addr_r == OFS_ENABLE_SET) begin
                enables_r <= enables_r | wmask;
            end else if (addr_r == OFS_ENABLE_CLEAR) begin
                enables_r <= enables_r & ~wmask;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrl_en_r <= 1'b0;
            ctrl_en_d_r <= 1'b0;
        end else if (clk_en) begin
            ctrl_en_d_r <= ctrl_en_r;
            if (wr_pend_r && addr_r == OFS_CONTROL) begin
                ctrl_en_r <= hwdata[BIT_CTRL_ENABLE];
            end
        end
    end

    // ----------------------------------------------------------------
    // transmit path tracking
    // ----------------------------------------------------------------
    assign tx_empty_path = !tx_pending_r && !shifter_busy && !tx_wr;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tx_pending_r <= 1'b0;
        end else if (clk_en) begin
            if (tx_wr) begin
                tx_pending_r <= 1'b1;
            end else if (tx_take) begin
                tx_pending_r <= 1'b0;
            end
        end
    end

    // count the configured delay after the path empties
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            delay_cnt_r <= '0;
            delay_run_r <= 1'b0;
        end else if (clk_en) begin
            if (!tx_empty_path) begin
                delay_cnt_r <= '0;
                delay_run_r <= 1'b1;
            end else if (delay_run_r && delay_cnt_r < xfer_delay) begin
                delay_cnt_r <= delay_cnt_r + 1'b1;
            end else begin
                delay_run_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // flags: hardware set wins over software clear
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            flags_r <= IRQ_RESET;
        end else if (clk_en) begin
            if (fl_write) begin
                flags_r[BIT_INSTRUCTION_END] <= !hwdata[BIT_INSTRUCTION_END]
                    && flags_r[BIT_INSTRUCTION_END];
                flags_r[BIT_SELECT_RISE] <= !hwdata[BIT_SELECT_RISE]
                    && flags_r[BIT_SELECT_RISE];
                flags_r[BIT_OVERRUN] <= !hwdata[BIT_OVERRUN] && flags_r[BIT_OVERRUN];
            end
            if (instr_end_evt) begin
                flags_r[BIT_INSTRUCTION_END] <= 1'b1;
            end
            if (cs_rise_evt) begin
                flags_r[BIT_SELECT_RISE] <= 1'b1;
            end
            if (rx_load && flags_r[BIT_RECEIVE_FULL] && !rx_rd) begin
                flags_r[BIT_OVERRUN] <= 1'b1;
            end
            // receive full: load wins over read
            if (rx_load) begin
                flags_r[BIT_RECEIVE_FULL] <= 1'b1;
            end else if (rx_rd) begin
                flags_r[BIT_RECEIVE_FULL] <= 1'b0;
            end
            if (tx_wr) begin
                flags_r[BIT_TRANSMIT_COMPLETE] <= 1'b0;
            end else if (tx_empty_path && !delay_run_r) begin
                flags_r[BIT_TRANSMIT_COMPLETE] <= 1'b1;
            end
            if (!ctrl_en_r) begin
                flags_r[BIT_TRANSMIT_EMPTY] <= 1'b0;
            end else if (!ctrl_en_d_r) begin
                flags_r[BIT_TRANSMIT_EMPTY] <= 1'b1;
            end else if (tx_wr) begin
                flags_r[BIT_TRANSMIT_EMPTY] <= 1'b0;
            end else if (tx_take && tx_pending_r) begin
                flags_r[BIT_TRANSMIT_EMPTY] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // read data and outputs
    // ----------------------------------------------------------------
    always_comb begin
        rdata_nxt = ZERO_WORD;
        if (haddr[7:0] == OFS_ENABLE_SET || haddr[7:0] == OFS_ENABLE_CLEAR) begin
            rdata_nxt = enables_r;
        end else if (haddr[7:0] == OFS_FLAGS) begin
            rdata_nxt = flags_r;
        end else if (haddr[7:0] == OFS_CONTROL) begin
            rdata_nxt = ZERO_WORD;
            rdata_nxt[BIT_CTRL_ENABLE] = ctrl_en_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            hrdata <= ZERO_WORD;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
            tx_write <= 1'b0;
            rx_read <= 1'b0;
            ctrl_enable <= 1'b0;
            irq <= 1'b0;
        end else if (clk_en) begin
            if (addr_ok && !hwrite) begin
                hrdata <= rdata_nxt;
            end
            tx_write <= tx_wr;
            rx_read <= rx_rd;
            ctrl_enable <= ctrl_en_r;
            irq <= |(flags_r & enables_r);
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_enable_set_bit: assert property (clk_en && wr_pend_r && addr_r == OFS_ENABLE_SET
        |=> (enables_r & $past(wmask)) == $past(wmask))
        else $error("enable set write lost");
    a_enable_zero_keep: assert property (clk_en && wr_pend_r && addr_r == OFS_ENABLE_SET
        |=> (enables_r & ~$past(wmask)) == ($past(enables_r) & ~$past(wmask)))
        else $error("enable set write changed other bits");
    a_enable_reads_back: assert property (clk_en && addr_ok && !hwrite
        && haddr[7:0] == OFS_ENABLE_SET |=> hrdata == $past(enables_r))
        else $error("enable readback wrong");
    a_instr_end_set: assert property (clk_en && instr_end_evt
        |=> flags_r[BIT_INSTRUCTION_END])
        else $error("instruction end not flagged");
    a_select_rise_set: assert property (clk_en && cs_rise_evt
        |=> flags_r[BIT_SELECT_RISE])
        else $error("select rise not flagged");
    a_overrun_set: assert property (clk_en && rx_load && flags_r[BIT_RECEIVE_FULL]
        && !rx_rd |=> flags_r[BIT_OVERRUN])
        else $error("overrun not flagged");
    a_flag_clear_one: assert property (clk_en && fl_write && hwdata[BIT_OVERRUN]
        && !(rx_load && flags_r[BIT_RECEIVE_FULL]) |=> !flags_r[BIT_OVERRUN])
        else $error("overrun not cleared");
    a_instr_end_clear: assert property (clk_en && fl_write
        && hwdata[BIT_INSTRUCTION_END] && !instr_end_evt |=> !flags_r[BIT_INSTRUCTION_END])
        else $error("instruction end not cleared");
    a_select_rise_clear: assert property (clk_en && fl_write
        && hwdata[BIT_SELECT_RISE] && !cs_rise_evt |=> !flags_r[BIT_SELECT_RISE])
        else $error("select rise not cleared");
    a_flag_zero_keep: assert property (clk_en && fl_write
        && !hwdata[BIT_SELECT_RISE] && flags_r[BIT_SELECT_RISE] |=> flags_r[BIT_SELECT_RISE])
        else $error("select rise lost on zero write");
    a_tx_complete_drop: assert property (clk_en && tx_wr
        |=> !flags_r[BIT_TRANSMIT_COMPLETE])
        else $error("transmit complete not dropped");
    a_tx_complete_set: assert property (clk_en && tx_empty_path && !delay_run_r
        |=> flags_r[BIT_TRANSMIT_COMPLETE])
        else $error("transmit complete not set");
    a_tx_complete_hold: assert property (clk_en && delay_run_r
        && !flags_r[BIT_TRANSMIT_COMPLETE] |=> !flags_r[BIT_TRANSMIT_COMPLETE])
        else $error("transmit complete set inside delay");
    a_tx_empty_low: assert property (clk_en && tx_wr && ctrl_en_r && ctrl_en_d_r
        |=> !flags_r[BIT_TRANSMIT_EMPTY])
        else $error("transmit empty not dropped");
    a_tx_empty_take: assert property (clk_en && ctrl_en_r && ctrl_en_d_r && !tx_wr
        && tx_take && tx_pending_r |=> flags_r[BIT_TRANSMIT_EMPTY])
        else $error("transmit empty not set on take");
    a_tx_empty_disabled: assert property (!ctrl_en_d_r && !ctrl_en_r
        |=> !flags_r[BIT_TRANSMIT_EMPTY])
        else $error("transmit empty set while disabled");
    a_tx_empty_enable: assert property (clk_en && ctrl_en_r && !ctrl_en_d_r
        |=> flags_r[BIT_TRANSMIT_EMPTY])
        else $error("transmit empty not set on enable");
    a_enable_clear_bit: assert property (clk_en && wr_pend_r && addr_r == OFS_ENABLE_CLEAR
        |=> (enables_r & $past(wmask)) == ZERO_WORD)
        else $error("enable clear write lost");
    a_receive_full_set: assert property (clk_en && rx_load
        |=> flags_r[BIT_RECEIVE_FULL])
        else $error("receive full not set");
    a_receive_read_clear: assert property (clk_en && rx_rd && !rx_load
        |=> !flags_r[BIT_RECEIVE_FULL])
        else $error("receive full not cleared by read");
    a_irq_follow: assert property (clk_en && |(flags_r & enables_r) |=> irq)
        else $error("interrupt not raised");
    a_irq_quiet: assert property (clk_en && !(|(flags_r & enables_r)) |=> !irq)
        else $error("interrupt raised without cause");

    c_tx_write: cover property (tx_wr);
    c_overrun: cover property (rx_load && flags_r[BIT_RECEIVE_FULL]);
    c_irq: cover property (irq);
    c_enable_on: cover property (ctrl_en_r && !ctrl_en_d_r);
    c_delay_done: cover property (delay_run_r && delay_cnt_r == xfer_delay);

endmodule

// ---- sim/testbench.sv ----
// self-checking bench for the interrupt enable and flag logic
`timescale 1ns/1ps
module testbench;
    import qspi_irq_pkg::*;
    // ---------------------------------------------------------------
    // signals and instance
    // ---------------------------------------------------------------
    logic mclk, nrst, clk_en, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic instr_end_evt, cs_rise_evt, rx_load, tx_take, shifter_busy;
    logic [7:0] xfer_delay;
    logic tx_write, rx_read, ctrl_enable, irq;
    int fail_count = 0;
    int n_checks = 0;
    int rx_reads = 0;
    int tx_writes = 0;
    // pulse counters for the controller-side strobes
    always @(posedge mclk) begin
        if (rx_read === 1'b1) begin
            rx_reads <= rx_reads + 1;
        end
        if (tx_write === 1'b1) begin
            tx_writes <= tx_writes + 1;
        end
    end
    // hready follows the single slave, so it is not a free input
    assign hready = hreadyout;
    qspi_irq_enable_flag_logic #(.DELAY_W(8)) qspi_irq_enable_flag_logic_inst (
        .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .instr_end_evt(instr_end_evt), .cs_rise_evt(cs_rise_evt), .rx_load(rx_load),
        .tx_take(tx_take), .shifter_busy(shifter_busy), .xfer_delay(xfer_delay),
        .tx_write(tx_write), .rx_read(rx_read), .ctrl_enable(ctrl_enable), .irq(irq));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // ---------------------------------------------------------------
    // bus and check helpers
    // ---------------------------------------------------------------
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait, no slave may hold the bus forever
    task automatic wait_ready;
        int i;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (hready !== 1'b1 && i < 50);
        if (hready !== 1'b1) begin
            fail_count++;
            $display("MISMATCH %0t bus wait ran out", $time);
            results();
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(a, 1'b0, ZERO_WORD);
        chk(r & m, e);
    endtask
    // one-cycle pulses, order: instruction end, select rise, receive load, take
    task automatic pulse(input logic [3:0] p);
        @(posedge mclk);
        {instr_end_evt, cs_rise_evt, rx_load, tx_take} <= p;
        @(posedge mclk);
        {instr_end_evt, cs_rise_evt, rx_load, tx_take} <= 4'h0;
    endtask
    task automatic irq_is(input logic e);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        rd(OFS_ENABLE_SET, 32'hFFFFFFFF, IRQ_RESET);
        rd(OFS_FLAGS, 32'h0000050B, ZERO_WORD);
        rd(OFS_FLAGS, 32'h00000004, 32'h00000004);
        chk({30'h0, hreadyout, hresp}, 32'h00000002);
        irq_is(1'b0);
        $display("reset values done");
    endtask
    task automatic t_enables;
        bus(OFS_ENABLE_SET, 1'b1, 32'hFFFFFFFF);
        rd(OFS_ENABLE_SET, 32'hFFFFFFFF, IRQ_MASK);
        bus(OFS_ENABLE_SET, 1'b1, ZERO_WORD);
        rd(OFS_ENABLE_SET, 32'hFFFFFFFF, IRQ_MASK);
        bus(OFS_ENABLE_CLEAR, 1'b1, 32'h00000401);
        rd(OFS_ENABLE_SET, 32'hFFFFFFFF, 32'h0000010E);
        bus(OFS_ENABLE_CLEAR, 1'b1, 32'hFFFFFFFF);
        rd(OFS_ENABLE_SET, 32'hFFFFFFFF, ZERO_WORD);
        $display("enable set and clear done");
    endtask
    task automatic t_events;
        bus(OFS_ENABLE_SET, 1'b1, 32'h00000400);
        pulse(4'h8);
        rd(OFS_FLAGS, 32'h00000509, 32'h00000400);
        irq_is(1'b1);
        bus(OFS_FLAGS, 1'b1, ZERO_WORD);
        rd(OFS_FLAGS, 32'h00000509, 32'h00000400);
        bus(OFS_FLAGS, 1'b1, 32'h00000400);
        rd(OFS_FLAGS, 32'h00000509, ZERO_WORD);
        irq_is(1'b0);
        pulse(4'h4);
        rd(OFS_FLAGS, 32'h00000509, 32'h00000100);
        irq_is(1'b0);
        bus(OFS_FLAGS, 1'b1, 32'h00000100);
        rd(OFS_FLAGS, 32'h00000509, ZERO_WORD);
        $display("event flags done");
    endtask
    task automatic t_receive;
        // frozen clock enable: this load must leave no trace
        clk_en <= 1'b0;
        pulse(4'h2);
        @(posedge mclk);
        clk_en <= 1'b1;
        rd(OFS_FLAGS, 32'h00000509, ZERO_WORD);
        pulse(4'h2);
        rd(OFS_FLAGS, 32'h00000509, 32'h00000001);
        pulse(4'h2);
        rd(OFS_FLAGS, 32'h00000509, 32'h00000009);
        rd(OFS_RECEIVE_DATA, 32'hFFFFFFFF, ZERO_WORD);
        rd(OFS_FLAGS, 32'h00000509, 32'h00000008);
        chk(rx_reads, 32'h00000001);
        bus(OFS_FLAGS, 1'b1, 32'h00000008);
        rd(OFS_FLAGS, 32'h00000509, ZERO_WORD);
        $display("receive flags done");
    endtask
    task automatic t_transmit;
        bus(OFS_CONTROL, 1'b1, 32'h00000002);
        rd(OFS_FLAGS, 32'h00000002, 32'h00000002);
        chk({31'h0, ctrl_enable}, 32'h00000001);
        shifter_busy <= 1'b1;
        bus(OFS_TRANSMIT_DATA, 1'b1, 32'h0000A5C3);
        rd(OFS_FLAGS, 32'h00000006, ZERO_WORD);
        chk(tx_writes, 32'h00000001);
        pulse(4'h1);
        rd(OFS_FLAGS, 32'h00000006, 32'h00000002);
        bus(OFS_ENABLE_SET, 1'b1, 32'h00000004);
        @(posedge mclk);
        shifter_busy <= 1'b0;
        // the delay is 20 cycles, so this read lands well inside it
        rd(OFS_FLAGS, 32'h00000004, ZERO_WORD);
        repeat (30) @(posedge mclk);
        rd(OFS_FLAGS, 32'h00000004, 32'h00000004);
        irq_is(1'b1);
        $display("transmit flags done");
    endtask
    task automatic t_reset_again;
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rd(OFS_ENABLE_SET, 32'hFFFFFFFF, IRQ_RESET);
        rd(OFS_FLAGS, 32'h0000050B, ZERO_WORD);
        chk({31'h0, ctrl_enable}, ZERO_WORD);
        irq_is(1'b0);
        $display("mid-run reset done");
    endtask
    initial begin
        nrst = 1'b0;
        clk_en = 1'b1;
        hsel = 1'b0;
        haddr = ZERO_WORD;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = ZERO_WORD;
        {instr_end_evt, cs_rise_evt, rx_load, tx_take} = 4'h0;
        shifter_busy = 1'b0;
        xfer_delay = 8'h14;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_enables();
        t_events();
        t_receive();
        t_transmit();
        t_reset_again();
        results();
    end
endmodule
